// ==== rivm_defs.vh ====
// Purpose: Constants for the reset and interrupt vector map
// Assumes: Word-addressed program memory, 16-bit program counter
// Notes: Included by rivm_vector_map.v
`ifndef RIVM_DEFS_VH
`define RIVM_DEFS_VH
`define RIVM_PC_W 16
`define RIVM_SRC_N 30
`define RIVM_VEC_W 5
`define RIVM_SLOT_WORDS 16'h0002
`define RIVM_RESET_ADDR 16'h0000
`define RIVM_RESET_VEC_NO 5'h01
`define RIVM_FIRST_IRQ_NO 5'h02
`define RIVM_CHG_CYCLES 3'h4
`define RIVM_CNT_W 3
`define RIVM_CNT_ONE 3'h1
`define RIVM_CNT_ZERO 3'h0
`endif

// ==== rivm_vector_map.v ====
// Purpose: Reset and interrupt vector address generator for an 8-bit core
// Assumes: Requests are same-clock levels from peripheral logic
// Notes: Single clock, no software-visible registers; control bits are ports
`timescale 1ns/1ps
`include "rivm_defs.vh"

module rivm_vector_map #(
    parameter PC_W = `RIVM_PC_W,
    parameter SRC_N = `RIVM_SRC_N
) (
    // Clock and reset
    input wire clock_i,
    input wire arst_n_i,
    // Fuses and boot layout
    input wire boot_reset_select_fuse_i,
    input wire [PC_W-1:0] boot_start_addr_i,
    // Core control register write port
    input wire ctrl_wr_i,
    input wire vector_table_select_wd_i,
    input wire vector_change_enable_wd_i,
    // Reset and interrupt requests, bit 0 is vector 2
    input wire reset_take_i,
    input wire [SRC_N-1:0] irq_req_i,
    input wire global_irq_en_i,
    // Answers to the fetch logic
    output reg [PC_W-1:0] target_addr_o,
    output reg target_valid_o,
    output reg [`RIVM_VEC_W-1:0] vector_no_o,
    output reg irq_pending_o,
    output reg vector_table_select_o,
    output reg vector_change_enable_o
);

// Limitations: requests are taken as levels, so a held request repeats its target
// every cycle; clearing the source is the requester's job. The boot start is taken
// as given; its size encoding lives outside this block.
// The request bus must be no wider than the vector number can count.

// ************************************************************
// Source order
// ************************************************************
// Request bit of each source; its vector number is the bit plus two
// Analog comparators
localparam SRC_COMP_0 = 0;
localparam SRC_COMP_1 = 1;
localparam SRC_COMP_2 = 2;
localparam SRC_COMP_3 = 3;

// Power stage controller
localparam SRC_STAGE_FAULT = 4;
localparam SRC_STAGE_END = 5;

// External requests
localparam SRC_EXT_REQ_0 = 6;
localparam SRC_EXT_REQ_1 = 7;
localparam SRC_EXT_REQ_2 = 8;
localparam SRC_EXT_REQ_3 = 9;

// Sixteen-bit timer
localparam SRC_TMR1_CAPTURE = 10;
localparam SRC_TMR1_MATCH_A = 11;
localparam SRC_TMR1_MATCH_B = 12;
localparam SRC_TMR1_WRAP = 13;

// Eight-bit timer
localparam SRC_TMR0_MATCH_A = 14;
localparam SRC_TMR0_MATCH_B = 15;
localparam SRC_TMR0_WRAP = 16;

// Bus controllers
localparam SRC_CAN_EVENT = 17;
localparam SRC_CAN_TMR_WRAP = 18;
localparam SRC_LIN_DONE = 19;
localparam SRC_LIN_FAULT = 20;

// Pin change requests
localparam SRC_PIN_CHG_0 = 21;
localparam SRC_PIN_CHG_1 = 22;
localparam SRC_PIN_CHG_2 = 23;
localparam SRC_PIN_CHG_3 = 24;

// Serial, converter, watchdog and memory
localparam SRC_SPI_DONE = 25;
localparam SRC_ADC_DONE = 26;
localparam SRC_WDOG = 27;
localparam SRC_EEPROM_READY = 28;
localparam SRC_STORE_PROGRAM_READY = 29;

// ************************************************************
// Change window states
// ************************************************************
localparam CHG_IDLE = 1'b0;
localparam CHG_ARMED = 1'b1;

// ************************************************************
// Change-protection window
// ************************************************************
reg [`RIVM_CNT_W-1:0] chg_cnt_reg;
reg [`RIVM_CNT_W-1:0] chg_cnt_next;
reg chg_state_reg;
reg chg_state_next;
reg sel_next;

// An enable write arms; a plain write only counts while armed
wire arm_wr = ctrl_wr_i & vector_change_enable_wd_i;
wire sel_wr = ctrl_wr_i & ~vector_change_enable_wd_i;

always @* begin
    chg_state_next = chg_state_reg;
    chg_cnt_next = chg_cnt_reg;
    sel_next = vector_table_select_o;
    case (chg_state_reg)
        CHG_IDLE: begin
            // A select write outside the window is dropped on purpose
            if (arm_wr) begin
                chg_state_next = CHG_ARMED;
                chg_cnt_next = `RIVM_CHG_CYCLES;
            end
        end
        CHG_ARMED: begin
            chg_cnt_next = chg_cnt_reg - `RIVM_CNT_ONE;
            if (arm_wr) begin
                // Writing the enable again restarts the window
                chg_cnt_next = `RIVM_CHG_CYCLES;
            end else if (sel_wr) begin
                sel_next = vector_table_select_wd_i;
                chg_state_next = CHG_IDLE;
                chg_cnt_next = `RIVM_CNT_ZERO;
            end else if (chg_cnt_reg == `RIVM_CNT_ONE) begin
                chg_state_next = CHG_IDLE;
            end
        end
        default: begin
            chg_state_next = CHG_IDLE;
            chg_cnt_next = `RIVM_CNT_ZERO;
        end
    endcase
end

always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        chg_state_reg <= CHG_IDLE;
        chg_cnt_reg <= `RIVM_CNT_ZERO;
        vector_table_select_o <= 1'b0;
        vector_change_enable_o <= 1'b0;
    end else begin
        chg_state_reg <= chg_state_next;
        chg_cnt_reg <= chg_cnt_next;
        vector_table_select_o <= sel_next;
        // Copy of the state so the port comes straight from a flop
        vector_change_enable_o <= chg_state_next;
    end
end

// Blocked in the arming write cycle and while the window stays open
wire irq_block = chg_state_reg | arm_wr;

// ************************************************************
// Priority pick and address forming
// ************************************************************
reg [`RIVM_VEC_W-1:0] idx;
reg found;
integer i;

always @* begin
    idx = {`RIVM_VEC_W{1'b0}};
    found = 1'b0;
    for (i = SRC_N - 1; i >= 0; i = i - 1) begin
        if (irq_req_i[i]) begin
            idx = i[`RIVM_VEC_W-1:0];
            found = 1'b1;
        end
    end
end

// Index widened to the address width before any arithmetic
wire [PC_W-1:0] idx_w = {{(PC_W-`RIVM_VEC_W){1'b0}}, idx};
// Two words per slot: index doubled, then past the reset slot
wire [PC_W-1:0] base_slot = {idx_w[PC_W-2:0], 1'b0} + `RIVM_SLOT_WORDS;

// ************************************************************
// Table relocation
// ************************************************************
// The select bit moves the interrupt table only; the fuse moves reset alone
wire [PC_W-1:0] irq_addr = vector_table_select_o ?
    base_slot + boot_start_addr_i : base_slot;
wire [PC_W-1:0] rst_addr = boot_reset_select_fuse_i ?
    `RIVM_RESET_ADDR : boot_start_addr_i;
// Reset outranks any request, so the window never holds it off
wire irq_go = found & global_irq_en_i & ~irq_block;

// ************************************************************
// Target register
// ************************************************************

always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        target_addr_o <= `RIVM_RESET_ADDR;
        target_valid_o <= 1'b0;
        vector_no_o <= `RIVM_RESET_VEC_NO;
        irq_pending_o <= 1'b0;
    end else begin
        irq_pending_o <= found;
        if (reset_take_i) begin
            target_addr_o <= rst_addr;
            vector_no_o <= `RIVM_RESET_VEC_NO;
            target_valid_o <= 1'b1;
        end else if (irq_go) begin
            target_addr_o <= irq_addr;
            vector_no_o <= idx + `RIVM_FIRST_IRQ_NO;
            target_valid_o <= 1'b1;
        end else begin
            target_valid_o <= 1'b0;
        end
    end
end

endmodule // rivm_vector_map

// ==== rivm_checker.sv ====
// Purpose: Port assertions for the vector map
// Assumes: Fuse and boot start held steady
// Notes: Bound from the bench top
`timescale 1ns/1ps
module rivm_checker #(parameter PC_W = 16, parameter SRC_N = 30) (
    input wire clock_i, arst_n_i, boot_reset_select_fuse_i, ctrl_wr_i, reset_take_i,
    input wire global_irq_en_i, vector_change_enable_wd_i, vector_table_select_wd_i,
    input wire target_valid_o, vector_table_select_o, vector_change_enable_o,
    input wire [4:0] vector_no_o, input wire [PC_W-1:0] boot_start_addr_i, target_addr_o,
    input wire [SRC_N-1:0] irq_req_i);
    wire c = vector_change_enable_o, v = target_valid_o, w = ctrl_wr_i;
    wire [4:0] n = vector_no_o;
    wire [SRC_N-1:0] low = irq_req_i & -irq_req_i;
    wire [PC_W-1:0] a = target_addr_o, s = boot_start_addr_i;
    // The write that arms the change also holds requests off
    wire b = c | w & vector_change_enable_wd_i;
    wire t = |irq_req_i & global_irq_en_i & !b & !reset_take_i;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    a_reset_vec: assert property (reset_take_i |=> v && n == 5'h01 &&
        a == (boot_reset_select_fuse_i ? 16'h0000 : s)) else $error("bad reset");
    a_slot_addr: assert property (v && n != 5'h01 |->
        a == (vector_table_select_o ? s : 16'h0000) + {n - 5'h01, 1'b0}) else $error("bad slot");
    a_lowest_win: assert property (t |=> v &&
        30'h1 << n - 5'h02 == $past(low)) else $error("bad winner");
    a_block_irq: assert property (b && !reset_take_i |=> !v) else $error("not held off");
    a_idle_quiet: assert property (!reset_take_i && !t |=> !v) else $error("stray");
    a_ce_expire: assert property (($rose(c) && !w) ##1 !w [*3] |-> c ##1 !c)
        else $error("bad expiry");
    a_sel_write: assert property (c && w && !vector_change_enable_wd_i |=> !c &&
        vector_table_select_o == $past(vector_table_select_wd_i)) else $error("lost write");
    a_sel_guard: assert property (!c |=> $stable(vector_table_select_o))
        else $error("unarmed change");
endmodule // rivm_checker

// ==== rivm_fetch_model.sv ====
// Purpose: Fetch-side stand-in loading its counter from each target
// Assumes: At most one target a cycle
// Notes: Jumps on the edge after the target shows
`timescale 1ns/1ps
module rivm_fetch_model (input wire clock_i, input wire valid_i, input wire [15:0] addr_i,
    output reg [15:0] pc_o);
    always @(posedge clock_i) if (valid_i) pc_o <= addr_i;
endmodule // rivm_fetch_model

// ==== test_reset_interrupt_vector_map.sv ====
// Purpose: Self-checking bench for the vector map
// Assumes: Inputs move 1 ns after each rising edge
// Notes: Boot start value is arbitrary
`timescale 1ns/1ps
module test_reset_interrupt_vector_map;
    reg clock_i = 0, arst_n_i = 0, boot_reset_select_fuse_i = 1, ctrl_wr_i = 0, reset_take_i = 0;
    reg vector_table_select_wd_i = 0, vector_change_enable_wd_i = 0, global_irq_en_i = 1;
    reg [15:0] boot_start_addr_i = 16'h0c00;
    reg [29:0] irq_req_i = 30'h0;
    wire [15:0] target_addr_o, pc;
    wire [4:0] vector_no_o;
    wire target_valid_o, vector_table_select_o, vector_change_enable_o, irq_pending_o;
    wire [21:0] out = {target_valid_o, vector_no_o, target_addr_o};
    integer n_errors = 0, num_checks = 0, k;
    always #2.5 clock_i = ~clock_i;
    rivm_vector_map i_dut (.*);
    rivm_fetch_model i_fetch (.clock_i, .valid_i(target_valid_o), .addr_i(target_addr_o), .pc_o(pc));
    task tick; begin @(posedge clock_i); #1; end endtask
    task chk(input [21:0] seen, input [21:0] exp); begin
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
        end
    end endtask
    task wr(input ce, input sel); begin
        ctrl_wr_i = 1; vector_change_enable_wd_i = ce; vector_table_select_wd_i = sel;
        tick; ctrl_wr_i = 0;
    end endtask
    task t_reset; begin
        for (k = 0; k < 2; k = k + 1) begin
            boot_reset_select_fuse_i = k == 0; reset_take_i = 1; tick; reset_take_i = 0;
            chk(out, {6'h21, k ? boot_start_addr_i : 16'h0000});
            tick;
        end
    end endtask
    task t_irq; begin
        // Every bit at or above k is raised, so k must win
        for (k = 0; k < 30; k = k + 1) begin
            irq_req_i = ~30'h0 << k; tick;
            chk(out, {1'b1, 5'h02 + k[4:0], 16'h0002 + {k[14:0], 1'b0}});
        end
        irq_req_i = 30'h0; tick;
    end endtask
    task t_mask; begin
        // Masked request shows as pending but is not taken
        global_irq_en_i = 0; irq_req_i = 30'h4; tick;
        chk({target_valid_o, irq_pending_o}, 2'b01);
        global_irq_en_i = 1; tick;
        chk(out, {6'h24, 16'h0006});
        irq_req_i = 30'h0; tick;
        chk(irq_pending_o, 1'b0);
    end endtask
    task t_move; begin
        irq_req_i = 30'h1; wr(1, 0); tick;
        chk(target_valid_o, 1'b0);
        wr(0, 1);
        chk({target_valid_o, vector_table_select_o, vector_change_enable_o}, 3'b010);
        tick;
        chk(out, {6'h22, boot_start_addr_i + 16'h0002});
        irq_req_i = 30'h0; wr(1, 0); tick; tick; tick;
        chk({vector_change_enable_o, pc}, {1'b1, boot_start_addr_i + 16'h0002});
        tick; wr(0, 0);
        chk({vector_change_enable_o, vector_table_select_o}, 2'b01);
    end endtask
    task end_sim; begin
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    end endtask
    initial begin
        repeat (12) @(posedge clock_i);
        #1 arst_n_i = 1;
        t_reset; t_irq; t_mask; t_move; end_sim;
    end
    initial begin #2000; n_errors = n_errors + 1; end_sim; end
endmodule // test_reset_interrupt_vector_map
bind rivm_vector_map rivm_checker #(.PC_W(PC_W), .SRC_N(SRC_N)) i_chk (.*);
